/* chop_pkg.sv */
`default_nettype none
package chop_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the APB bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DELAY_OFS = 8'h04;
    localparam logic [7:0] CMD_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] RESULT_OFS = 8'h10;

    // Field positions
    localparam int CTRL_CHOP_BIT = 0;
    localparam int CTRL_SINC3_BIT = 1;
    localparam int CTRL_RATE_LSB = 2;
    localparam int CTRL_CONT_BIT = 6;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_REV_BIT = 1;
    localparam int ST_READY_BIT = 2;
    localparam int ST_PAIR_BIT = 3;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset and timing
    localparam int DATA_W = 24;
    localparam int TMOD_W = 20;
    localparam int RATE_COUNT = 14;
    localparam logic [3:0] RATE_MAX = 4'hd;
    localparam logic [7:0] DELAY_RESET = 8'h0e;
    localparam logic [3:0] RATE_RESET = 4'h0;
    localparam int MCLK_PER_TMOD = 16;

    // First data period in modulator periods, slowest rate first
    localparam logic [TMOD_W-1:0] LL_FIRST_TMOD [RATE_COUNT] = '{
        20'd208130, 20'd105730, 20'd54530, 20'd30850, 20'd28930, 20'd10320, 20'd8658,
        20'd5200, 20'd2640, 20'd1360, 20'd720, 20'd592, 20'd336, 20'd208};
    localparam logic [TMOD_W-1:0] SINC3_FIRST_TMOD [RATE_COUNT] = '{
        20'd614530, 20'd307330, 20'd153730, 20'd92290, 20'd76930, 20'd30850, 20'd25714,
        20'd15490, 20'd7810, 20'd3970, 20'd2050, 20'd1616, 20'd848, 20'd464};

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SETTLE = 2'b01,
        SEQ_CONVERT = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic continuous;
        logic [3:0] rate;
        logic sinc3;
        logic chop_en;
    } cfg_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } result_t;
endpackage
`default_nettype wire

/* period_rom.sv */
`default_nettype none
module period_rom
    import chop_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sinc3,
    input wire logic [3:0] rate,
    output logic [TMOD_W-1:0] first_tmod
);
    logic [3:0] idx;

    // Out-of-range rate codes fall back to the fastest rate
    assign idx = (rate > RATE_MAX) ? RATE_MAX : rate;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_tmod <= LL_FIRST_TMOD[0];
        end else if (sinc3) begin
            first_tmod <= SINC3_FIRST_TMOD[idx];
        end else begin
            first_tmod <= LL_FIRST_TMOD[idx];
        end
    end
endmodule
`default_nettype wire

/* chop_sequencer.sv */
`default_nettype none
module chop_sequencer
    import chop_pkg::*;
#(
    parameter int MOD_CYCLES = MCLK_PER_TMOD,
    parameter int PERIOD_DIV = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic start_pin,
    input wire logic [DATA_W-1:0] conv_data,
    output logic input_reversed,
    output logic conv_run,
    output result_t result
);
    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state per access
    cfg_t cfg_reg;
    logic [7:0] delay_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic acc, wr_en, rd_en, mapped;
    logic cmd_start, cmd_stop;
    logic ready_reg, reversed_reg, have_prev_reg;
    result_t result_reg;
    seq_state_t state_reg;
    logic [31:0] status_word;

    assign acc = psel && penable && !pready_reg;
    assign wr_en = psel && penable && pready_reg && pwrite;
    assign rd_en = psel && penable && pready_reg && !pwrite;
    assign mapped = (paddr == CTRL_OFS) || (paddr == DELAY_OFS) || (paddr == CMD_OFS)
        || (paddr == STATUS_OFS) || (paddr == RESULT_OFS);
    assign cmd_start = wr_en && (paddr == CMD_OFS) && pwdata[CMD_START_BIT];
    assign cmd_stop = wr_en && (paddr == CMD_OFS) && pwdata[CMD_STOP_BIT];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_BUSY_BIT] = (state_reg != SEQ_IDLE);
        status_word[ST_REV_BIT] = reversed_reg;
        status_word[ST_READY_BIT] = ready_reg;
        status_word[ST_PAIR_BIT] = have_prev_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= acc;
            pslverr_reg <= acc && !mapped;
            prdata_reg <= 32'h0000_0000;
            if (acc && !pwrite) begin
                case (paddr)
                    CTRL_OFS: prdata_reg <= {25'h0, cfg_reg};
                    DELAY_OFS: prdata_reg <= {24'h0, delay_reg};
                    STATUS_OFS: prdata_reg <= status_word;
                    RESULT_OFS: prdata_reg <= {8'h00, result_reg.data};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= '{continuous: 1'b1, rate: RATE_RESET, sinc3: 1'b0, chop_en: 1'b0};
            delay_reg <= DELAY_RESET;
        end else if (wr_en && paddr == CTRL_OFS) begin
            cfg_reg <= pwdata[CTRL_CONT_BIT:CTRL_CHOP_BIT];
        end else if (wr_en && paddr == DELAY_OFS) begin
            delay_reg <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger pin synchroniser and start detection
    logic pin_meta, pin_sync, pin_last, trig;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_last <= 1'b0;
        end else begin
            pin_meta <= start_pin;
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    assign trig = (pin_sync && !pin_last) || cmd_start;

    ////////////////////////////////////////////////////////////////////////
    // Period lookup; the table holds the whole first chop period
    logic [TMOD_W-1:0] first_tmod, first_div, half_tmod;

    period_rom u_rom (
        .pclk(pclk),
        .presetn(presetn),
        .sinc3(cfg_reg.sinc3),
        .rate(cfg_reg.rate),
        .first_tmod(first_tmod)
    );

    assign first_div = first_tmod / TMOD_W'(PERIOD_DIV);
    // Each polarity conversion is half the first period
    assign half_tmod = (first_div > TMOD_W'(3)) ? (first_div >> 1) : TMOD_W'(1);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: settle, convert, collect
    logic [TMOD_W-1:0] tmod_cnt;
    logic [7:0] sub_cnt;
    logic phase_end, conv_end, chop_rise, chop_last;
    logic conv_run_reg;

    assign phase_end = (tmod_cnt == '0) && (sub_cnt == '0);
    assign conv_end = (state_reg == SEQ_CONVERT) && phase_end && !trig && !cmd_stop;

    // Counting master clocks per modulator period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SEQ_IDLE;
            tmod_cnt <= '0;
            sub_cnt <= 8'h00;
            conv_run_reg <= 1'b0;
        end else if (cmd_stop) begin
            state_reg <= SEQ_IDLE;
            conv_run_reg <= 1'b0;
        end else if (trig || (state_reg == SEQ_CONVERT && phase_end
                && (cfg_reg.continuous || (cfg_reg.chop_en && !have_prev_reg)))) begin
            sub_cnt <= 8'(MOD_CYCLES - 1);
            if (delay_reg != 8'h00) begin
                state_reg <= SEQ_SETTLE;
                tmod_cnt <= TMOD_W'(delay_reg) - TMOD_W'(1);
                conv_run_reg <= 1'b0;
            end else begin
                state_reg <= SEQ_CONVERT;
                tmod_cnt <= half_tmod - TMOD_W'(1);
                conv_run_reg <= 1'b1;
            end
        end else begin
            case (state_reg)
                SEQ_IDLE: begin
                    conv_run_reg <= 1'b0;
                end
                SEQ_SETTLE, SEQ_CONVERT: begin
                    if (phase_end) begin
                        if (state_reg == SEQ_SETTLE) begin
                            state_reg <= SEQ_CONVERT;
                            tmod_cnt <= half_tmod - TMOD_W'(1);
                            sub_cnt <= 8'(MOD_CYCLES - 1);
                            conv_run_reg <= 1'b1;
                        end else begin
                            // Single-shot ends after one result
                            state_reg <= SEQ_IDLE;
                            conv_run_reg <= 1'b0;
                        end
                    end else if (sub_cnt == 8'h00) begin
                        sub_cnt <= 8'(MOD_CYCLES - 1);
                        tmod_cnt <= tmod_cnt - TMOD_W'(1);
                    end else begin
                        sub_cnt <= sub_cnt - 8'h01;
                    end
                end
                default: begin
                    state_reg <= SEQ_IDLE;
                    conv_run_reg <= 1'b0;
                end
            endcase
        end
    end

    assign conv_run = conv_run_reg;

    ////////////////////////////////////////////////////////////////////////
    // Polarity and pairing of results
    logic [DATA_W-1:0] prev_data;
    logic [DATA_W:0] diff;
    logic [DATA_W-1:0] normal_val, reversed_val;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chop_last <= 1'b0;
        end else begin
            chop_last <= cfg_reg.chop_en;
        end
    end

    assign chop_rise = cfg_reg.chop_en && !chop_last;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reversed_reg <= 1'b0;
            have_prev_reg <= 1'b0;
            prev_data <= '0;
        end else if (trig || chop_rise || !cfg_reg.chop_en) begin
            reversed_reg <= 1'b0;
            have_prev_reg <= 1'b0;
        end else if (conv_end) begin
            reversed_reg <= !reversed_reg;
            have_prev_reg <= 1'b1;
            prev_data <= conv_data;
        end
    end

    assign input_reversed = reversed_reg;

    // The reversed conversion reads the signal negated, so subtract
    assign normal_val = reversed_reg ? prev_data : conv_data;
    assign reversed_val = reversed_reg ? conv_data : prev_data;
    assign diff = {normal_val[DATA_W-1], normal_val} - {reversed_val[DATA_W-1], reversed_val};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= '0;
        end else begin
            result_reg.valid <= 1'b0;
            if (conv_end && cfg_reg.chop_en && have_prev_reg && !chop_rise) begin
                result_reg.valid <= 1'b1;
                result_reg.data <= diff[DATA_W:1];
            end else if (conv_end && !cfg_reg.chop_en) begin
                result_reg.valid <= 1'b1;
                result_reg.data <= conv_data;
            end
        end
    end

    assign result = result_reg;

    // Ready flag: a new result wins over a clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
        end else if (result_reg.valid) begin
            ready_reg <= 1'b1;
        end else if (rd_en && paddr == RESULT_OFS) begin
            ready_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [31:0] phase_cyc;
    logic [31:0] half_cyc, delay_cyc;

    assign half_cyc = 32'(half_tmod) * 32'(MOD_CYCLES);
    assign delay_cyc = 32'(delay_reg) * 32'(MOD_CYCLES);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_cyc <= 32'h0000_0000;
        end else if (trig || cmd_stop || (state_reg != SEQ_IDLE && phase_end)) begin
            // Loaded on the edge that opens a phase, so its last edge reads the full length
            phase_cyc <= 32'h0000_0001;
        end else begin
            phase_cyc <= phase_cyc + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_start_leaves_idle: assert property (
        trig && !cmd_stop |=> state_reg != SEQ_IDLE)
        else $error("Trigger did not start a sequence");
    a_settle_length: assert property (
        state_reg == SEQ_SETTLE && phase_end && !trig && !cmd_stop && $stable(delay_reg)
        |-> phase_cyc == delay_cyc)
        else $error("Settling delay length wrong");
    a_settle_each_conv: assert property (
        $rose(conv_run_reg) && delay_reg != 8'h00 && $stable(delay_reg)
        |-> $past(state_reg) == SEQ_SETTLE)
        else $error("Conversion began without settling");
    a_conv_half_length: assert property (
        conv_end && $stable(first_tmod) |-> phase_cyc == half_cyc)
        else $error("Conversion period is not half the first period");
    a_rom_slowest: assert property (
        (!cfg_reg.sinc3 && cfg_reg.rate == RATE_RESET) [*2]
        |-> first_tmod == LL_FIRST_TMOD[0])
        else $error("Low-latency slowest period wrong");
    a_rom_sinc3_fast: assert property (
        (cfg_reg.sinc3 && cfg_reg.rate == RATE_MAX) [*2]
        |-> first_tmod == SINC3_FIRST_TMOD[RATE_COUNT-1])
        else $error("Sinc3 fastest period wrong");
    a_swap_on_collect: assert property (
        conv_end && cfg_reg.chop_en && !chop_rise |=> reversed_reg != $past(reversed_reg))
        else $error("Polarity not reversed after a result");
    a_avg_each_cycle: assert property (
        conv_end && cfg_reg.chop_en && have_prev_reg && !chop_rise |=> result_reg.valid)
        else $error("Missing averaged output");
    a_no_early_result: assert property (
        conv_end && cfg_reg.chop_en && !have_prev_reg |=> !result_reg.valid)
        else $error("Chop result before two conversions");
    a_chop_off_normal: assert property (
        !cfg_reg.chop_en |=> !reversed_reg)
        else $error("Polarity reversed with chop off");
    a_trigger_clears: assert property (
        trig |=> !reversed_reg && !have_prev_reg)
        else $error("Trigger did not restore polarity");
    a_single_ends: assert property (
        conv_end && !cfg_reg.continuous && (have_prev_reg || !cfg_reg.chop_en)
        |=> state_reg == SEQ_IDLE && !conv_run_reg)
        else $error("Single-shot sequence did not stop");
    a_cont_pipeline: assert property (
        conv_end && cfg_reg.continuous |=> state_reg != SEQ_IDLE)
        else $error("Continuous sequence stopped");

    c_chop_average: cover property (conv_end && cfg_reg.chop_en && have_prev_reg);
    c_sinc3_run: cover property (cfg_reg.sinc3 && result_reg.valid);
    c_pin_start: cover property (pin_sync && !pin_last);
    c_single_done: cover property (conv_end && !cfg_reg.continuous && have_prev_reg);
    c_raw_result: cover property (conv_end && !cfg_reg.chop_en);
endmodule
`default_nettype wire

/* far_side_model.sv */
`default_nettype none
module far_side_model
    import chop_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trig_req,
    input wire logic [DATA_W-1:0] sig_val,
    input wire logic [DATA_W-1:0] ofs_val,
    input wire logic input_reversed,
    input wire logic conv_run,
    output logic start_pin,
    output logic [DATA_W-1:0] conv_data
);
    logic [2:0] hold_reg;
    logic flip_reg;

    // Pin held several cycles so the synchroniser cannot miss it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= 3'h0;
        end else if (trig_req) begin
            hold_reg <= 3'h5;
        end else if (hold_reg != 3'h0) begin
            hold_reg <= hold_reg - 3'h1;
        end
    end
    assign start_pin = (hold_reg != 3'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flip_reg <= 1'b0;
        end else begin
            flip_reg <= ~flip_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Offset enters both polarities alike; only a correct average cancels it.
    // Outside a conversion the data toggle, so a stale sample shows up.
    assign conv_data = !conv_run ? (flip_reg ? 24'haaaaaa : 24'h555555) :
        input_reversed ? ofs_val - sig_val : ofs_val + sig_val;
endmodule
`default_nettype wire

/* chop_sequencer_tb_top.sv */
`default_nettype none
module chop_sequencer_tb_top import chop_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PDIV = 64;
    localparam int MC = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic trig_req = 1'b0;
    logic pready, pslverr, input_reversed, conv_run, start_pin;
    logic [31:0] prdata;
    logic [DATA_W-1:0] conv_data;
    logic [DATA_W-1:0] sig_val = 24'h001234;
    logic [DATA_W-1:0] ofs_val = 24'h000500;
    result_t result;
    int bad_count = 0;
    int n_tests = 0;

    always #5 pclk = ~pclk;

    chop_sequencer #(.MOD_CYCLES(MC), .PERIOD_DIV(PDIV)) dut_u (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .start_pin(start_pin), .conv_data(conv_data),
        .input_reversed(input_reversed), .conv_run(conv_run), .result(result));

    far_side_model far_u (.pclk(pclk), .presetn(presetn), .trig_req(trig_req),
        .sig_val(sig_val), .ofs_val(ofs_val), .input_reversed(input_reversed),
        .conv_run(conv_run), .start_pin(start_pin), .conv_data(conv_data));

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic hang(input string what);
        $display("[ERR] %s expected answer seen timeout", what);
        bad_count++;
        finish_test();
    endtask

    // Called just after a rising edge; ends one edge after release
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic err);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) hang("pready");
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask

    task automatic rdreg(input logic [7:0] a, output logic [31:0] r);
        logic e;
        xfer(1'b0, a, 32'h0, r, e);
    endtask

    task automatic wait_valid(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (result.valid !== 1'b1 && n < 50000);
        if (n >= 50000) hang("result");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        logic [31:0] r;
        logic e;
        rdreg(CTRL_OFS, r);
        chk("ctrl_rst", 32'h40, r);
        rdreg(DELAY_OFS, r);
        chk("delay_rst", 32'h0e, r);
        xfer(1'b1, 8'h20, 32'hffff_ffff, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        rdreg(8'h20, r);
        chk("unmapped_data", 32'h0, r);
        rdreg(CMD_OFS, r);
        chk("cmd_read", 32'h0, r);
        $display("regs done");
    endtask

    task automatic test_timing(input logic s3, input logic [3:0] rate, input int first,
        input logic [7:0] dly);
        int h, n, lo;
        logic [31:0] r;
        h = (first / PDIV) / 2;
        lo = 2 * (dly + h) * MC;
        wr(DELAY_OFS, {24'h0, dly});
        wr(CTRL_OFS, {25'h0, 1'b1, rate, s3, 1'b1});
        wr(CMD_OFS, 32'h1);
        wait_valid(n);
        chk("first_gap", 32'h1, {31'h0, n >= lo && n <= lo + 8});
        chk("avg_first", {8'h0, sig_val}, {8'h0, result.data});
        chk("rev_first", 32'h0, {31'h0, input_reversed});
        for (int k = 0; k < 2; k++) begin
            wait_valid(n);
            chk("next_gap", (dly + h) * MC, n);
            chk("avg_next", {8'h0, sig_val}, {8'h0, result.data});
            chk("rev_next", {31'h0, k == 0}, {31'h0, input_reversed});
        end
        wr(CMD_OFS, 32'h3);
        rdreg(STATUS_OFS, r);
        chk("busy_stop", 32'h0, {31'h0, r[ST_BUSY_BIT]});
        $display("timing done");
    endtask

    task automatic pulse_pin();
        trig_req <= 1'b1;
        @(posedge pclk);
        trig_req <= 1'b0;
    endtask

    task automatic test_pin_restart();
        logic [31:0] r;
        int k, n;
        wr(DELAY_OFS, 32'h0);
        wr(CTRL_OFS, 32'h41);
        pulse_pin();
        k = 0;
        while (input_reversed !== 1'b1 && k < 20000) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 20000) hang("reversal");
        chk("run_conv", 32'h1, {31'h0, conv_run});
        rdreg(STATUS_OFS, r);
        chk("pair_held", 32'h1, {31'h0, r[ST_PAIR_BIT]});
        pulse_pin();
        repeat (8) @(posedge pclk);
        chk("rev_clear", 32'h0, {31'h0, input_reversed});
        rdreg(STATUS_OFS, r);
        chk("pair_clear", 32'h0, {31'h0, r[ST_PAIR_BIT]});
        wait_valid(n);
        chk("restart_gap", 32'h1, {31'h0, n >= 2 * ((208130 / PDIV) / 2) * MC - 20});
        wr(CMD_OFS, 32'h2);
        $display("pin restart done");
    endtask

    task automatic test_chop_off();
        int n;
        wr(DELAY_OFS, 32'h2);
        // Rate code above the top clamps to the fastest rate
        wr(CTRL_OFS, 32'h7c);
        wr(CMD_OFS, 32'h1);
        wait_valid(n);
        chk("raw_data", {8'h0, ofs_val + sig_val}, {8'h0, result.data});
        wait_valid(n);
        chk("raw_gap", (2 + (208 / PDIV) / 2) * MC, n);
        chk("rev_off", 32'h0, {31'h0, input_reversed});
        wr(CMD_OFS, 32'h2);
        $display("chop off done");
    endtask

    task automatic test_single();
        int n;
        logic [31:0] r;
        wr(DELAY_OFS, 32'h1);
        wr(CTRL_OFS, 32'h35);
        wr(CMD_OFS, 32'h1);
        wait_valid(n);
        chk("single_avg", {8'h0, sig_val}, {8'h0, result.data});
        repeat (4) @(posedge pclk);
        rdreg(STATUS_OFS, r);
        chk("single_status", 32'h4, r & 32'h7);
        chk("run_idle", 32'h0, {31'h0, conv_run});
        rdreg(RESULT_OFS, r);
        chk("result_reg", {8'h0, sig_val}, r);
        rdreg(STATUS_OFS, r);
        chk("ready_clear", 32'h0, r & 32'h4);
        rdreg(CTRL_OFS, r);
        chk("ctrl_back", 32'h35, r);
        $display("single done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_regs();
        test_timing(1'b0, 4'h0, 208130, 8'h0e);
        test_timing(1'b0, 4'hd, 208, 8'h0e);
        test_timing(1'b1, 4'h0, 614530, 8'h00);
        test_timing(1'b1, 4'hd, 464, 8'h03);
        test_pin_restart();
        test_chop_off();
        test_single();
        finish_test();
    end
endmodule
`default_nettype wire
